/* src/dlpr_pkg.sv */
// Purpose: Shared constants and types for the deframer link parameter bank
// Assumes: 8-bit registers behind a 15-bit serial configuration address
// Notes:   Reset values are plain defaults; software programs every field

package dlpr_pkg;

    // ************************************************************
    // Serial port framing
    // ************************************************************
    localparam int ADDR_W = 15;
    localparam logic [3:0] INSTR_LAST = 4'hF;  // 16 instruction bits
    localparam logic [2:0] DATA_LAST = 3'h7;   // 8 data bits
    localparam int RW_BIT = 14;                 // Read flag inside shift

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [14:0] OFF_LANE_SCR = 15'h0453;
    localparam logic [14:0] OFF_OPF_M1 = 15'h0454;
    localparam logic [14:0] OFF_FPM = 15'h0455;
    localparam logic [14:0] OFF_CONV = 15'h0456;
    localparam logic [14:0] OFF_CS_RES = 15'h0457;
    localparam logic [14:0] OFF_SUB_NP = 15'h0458;
    localparam logic [14:0] OFF_VER_SPF = 15'h0459;
    localparam logic [14:0] OFF_HD_CF = 15'h045A;
    localparam logic [14:0] OFF_DESKEW = 15'h046C;
    localparam logic [14:0] OFF_OPF_DIR = 15'h0476;
    localparam logic [14:0] OFF_LANE_EN = 15'h047D;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LOW5_HI = 4;    // Bits 4:0 count fields
    localparam int TOP3_LO = 5;    // Bits 7:5 subclass, version
    localparam int CS_LO = 6;      // Bits 7:6 control bits
    localparam int FLAG_BIT = 7;   // Scramble enable, high density

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {PH_INSTR, PH_DATA} dlpr_phase_t;

    typedef struct packed {
        logic [7:0] lane_count_and_scramble;
        logic [7:0] octets_per_frame_minus_one;
        logic [7:0] frames_per_multiframe;
        logic [7:0] converters_per_link;
        logic [7:0] control_bits_and_resolution;
        logic [7:0] subclass_and_sample_width;
        logic [7:0] version_and_samples_per_frame;
        logic [7:0] high_density_and_control_words;
        logic [7:0] lane_deskew_mask;
        logic [7:0] octets_per_frame_direct;
        logic [7:0] link_lane_enable_mask;
    } dlpr_regs_t;

    typedef struct packed {
        logic scramble_en;
        logic [4:0] lanes_m1;
        logic [7:0] octets_m1;
        logic [4:0] frames_m1;
        logic [7:0] conv_m1;
        logic [1:0] ctrl_bits;
        logic [4:0] resolution_m1;
        logic [2:0] subclass;
        logic [4:0] sample_bits_m1;
        logic [2:0] version;
        logic [4:0] samples_m1;
        logic high_density;
        logic [4:0] ctrl_words;
        logic [7:0] deskew_mask;
        logic [7:0] octets_direct;
        logic [7:0] lane_enable;
    } dlpr_link_t;

    typedef struct packed {
        dlpr_phase_t phase;
        logic [3:0] cnt;
        logic [15:0] shift;
        logic rw;
        logic [14:0] addr;
        logic [7:0] rd;
        logic sdo_oe_b;
        logic sclk_prev;
        dlpr_regs_t regs;
        dlpr_link_t link;
    } dlpr_state_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } dlpr_sync_t;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam dlpr_regs_t RST_REGS = '0;
    localparam dlpr_link_t RST_LINK = '0;
    localparam dlpr_state_t RST_STATE = '{phase: PH_INSTR, cnt: 4'h0,
        shift: 16'h0000, rw: 1'b0, addr: 15'h0000, rd: 8'h00,
        sdo_oe_b: 1'b1, sclk_prev: 1'b0, regs: RST_REGS, link: RST_LINK};

endpackage : dlpr_pkg

/* src/dlpr_sync.sv */
// Purpose: Two flip-flop synchroniser for one pin
// Assumes: Pin is asynchronous to CLOCK
// Notes:   First stage feeds only the second stage

module dlpr_sync import dlpr_pkg::*; #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Pin in, synchronised level out
    input wire logic PIN,
    output logic LEVEL
);

    dlpr_sync_t q, d;

    // Shift the pin through two stages
    always_comb begin
        d.meta = PIN;
        d.sync = q.meta;
    end

    // Register the stages
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign LEVEL = q.sync;

endmodule : dlpr_sync

/* src/dlpr_top.sv */
// Purpose: Link parameter register bank for a multi-lane receive deframer
// Assumes: Serial port pins are oversampled by CLOCK, SCLK at most CLOCK/8
// Notes:   16-bit instruction (read flag, 15-bit address), then data bytes
//          MSB first; address steps by one per byte while select stays low

module dlpr_top import dlpr_pkg::*; (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Serial configuration port
    input wire logic SCLK,
    input wire logic CS_B,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE_B,
    // Link parameters to the deframer
    output dlpr_link_t LINK_CFG
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic sclk_s;
    logic csb_s;
    logic sdi_s;

    dlpr_sync #(.RST_VAL(1'b0)) u_sync_sclk (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .PIN(SCLK),
        .LEVEL(sclk_s)
    );

    dlpr_sync #(.RST_VAL(1'b1)) u_sync_csb (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .PIN(CS_B),
        .LEVEL(csb_s)
    );

    dlpr_sync #(.RST_VAL(1'b0)) u_sync_sdi (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .PIN(SDI),
        .LEVEL(sdi_s)
    );

    // ************************************************************
    // Helpers
    // ************************************************************

    // Read mux, unmapped offsets read as zero
    function automatic logic [7:0] rd_val(dlpr_regs_t r, logic [14:0] a);
        logic [7:0] v;
        v = UNMAPPED_RD;
        unique case (a)
            OFF_LANE_SCR: v = r.lane_count_and_scramble;
            OFF_OPF_M1: v = r.octets_per_frame_minus_one;
            OFF_FPM: v = r.frames_per_multiframe;
            OFF_CONV: v = r.converters_per_link;
            OFF_CS_RES: v = r.control_bits_and_resolution;
            OFF_SUB_NP: v = r.subclass_and_sample_width;
            OFF_VER_SPF: v = r.version_and_samples_per_frame;
            OFF_HD_CF: v = r.high_density_and_control_words;
            OFF_DESKEW: v = r.lane_deskew_mask;
            OFF_OPF_DIR: v = r.octets_per_frame_direct;
            OFF_LANE_EN: v = r.link_lane_enable_mask;
            default: v = UNMAPPED_RD;
        endcase
        return v;
    endfunction : rd_val

    // Split register bytes into deframer fields
    function automatic dlpr_link_t decode(dlpr_regs_t r);
        dlpr_link_t l;
        l = RST_LINK;
        l.scramble_en = r.lane_count_and_scramble[FLAG_BIT];
        l.lanes_m1 = r.lane_count_and_scramble[LOW5_HI:0];
        l.octets_m1 = r.octets_per_frame_minus_one;
        l.frames_m1 = r.frames_per_multiframe[LOW5_HI:0];
        l.conv_m1 = r.converters_per_link;
        l.ctrl_bits = r.control_bits_and_resolution[FLAG_BIT:CS_LO];
        l.resolution_m1 = r.control_bits_and_resolution[LOW5_HI:0];
        l.subclass = r.subclass_and_sample_width[FLAG_BIT:TOP3_LO];
        l.sample_bits_m1 = r.subclass_and_sample_width[LOW5_HI:0];
        l.version = r.version_and_samples_per_frame[FLAG_BIT:TOP3_LO];
        l.samples_m1 = r.version_and_samples_per_frame[LOW5_HI:0];
        l.high_density = r.high_density_and_control_words[FLAG_BIT];
        l.ctrl_words = r.high_density_and_control_words[LOW5_HI:0];
        // Deskew only where the lane is enabled
        l.deskew_mask = r.lane_deskew_mask & r.link_lane_enable_mask;
        l.octets_direct = r.octets_per_frame_direct;
        l.lane_enable = r.link_lane_enable_mask;
        return l;
    endfunction : decode

    // ************************************************************
    // Serial port engine and register file
    // ************************************************************
    dlpr_state_t q, d;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_en;
    logic [7:0] wr_data;
    logic [14:0] instr_addr;

    // Edges of the synchronised serial clock
    assign sclk_rise = sclk_s & ~q.sclk_prev;
    assign sclk_fall = ~sclk_s & q.sclk_prev;
    assign wr_data = {q.shift[6:0], sdi_s};
    assign instr_addr = {q.shift[13:0], sdi_s};

    // Next state of the whole block
    always_comb begin
        d = q;
        wr_en = 1'b0;
        d.sclk_prev = sclk_s;
        if (csb_s) begin
            // Deselect aborts any partial byte and releases SDO
            d.phase = PH_INSTR;
            d.cnt = 4'h0;
            d.sdo_oe_b = 1'b1;
        end else if (sclk_rise) begin
            d.shift = {q.shift[14:0], sdi_s};
            unique case (q.phase)
                PH_INSTR: begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == INSTR_LAST) begin
                        d.phase = PH_DATA;
                        d.cnt = 4'h0;
                        d.rw = q.shift[RW_BIT];
                        d.addr = instr_addr;
                        if (q.shift[RW_BIT]) begin
                            d.rd = rd_val(q.regs, instr_addr);
                            d.sdo_oe_b = 1'b0;
                        end
                    end
                end
                PH_DATA: begin
                    d.cnt = {1'b0, q.cnt[2:0] + 3'h1};
                    if (q.cnt[2:0] == DATA_LAST) begin
                        d.cnt = 4'h0;
                        d.addr = q.addr + 15'h0001;
                        if (q.rw) begin
                            d.rd = rd_val(q.regs, q.addr + 15'h0001);
                        end else begin
                            wr_en = 1'b1;
                        end
                    end
                end
            endcase
        end else if (sclk_fall && q.phase == PH_DATA && q.rw && q.cnt != 4'h0) begin
            // Next read bit leaves on the falling edge
            d.rd = {q.rd[6:0], 1'b0};
        end

        // Register write on the last data bit
        if (wr_en) begin
            unique case (q.addr)
                OFF_LANE_SCR: d.regs.lane_count_and_scramble = wr_data;
                OFF_OPF_M1: d.regs.octets_per_frame_minus_one = wr_data;
                OFF_FPM: d.regs.frames_per_multiframe = wr_data;
                OFF_CONV: d.regs.converters_per_link = wr_data;
                OFF_CS_RES: d.regs.control_bits_and_resolution = wr_data;
                OFF_SUB_NP: d.regs.subclass_and_sample_width = wr_data;
                OFF_VER_SPF: d.regs.version_and_samples_per_frame = wr_data;
                OFF_HD_CF: d.regs.high_density_and_control_words = wr_data;
                OFF_DESKEW: d.regs.lane_deskew_mask = wr_data;
                OFF_OPF_DIR: d.regs.octets_per_frame_direct = wr_data;
                OFF_LANE_EN: d.regs.link_lane_enable_mask = wr_data;
                default: d.regs = q.regs;
            endcase
        end

        // Outputs follow the stored bytes in the same cycle
        d.link = decode(d.regs);
    end

    // State register
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    // Output drive
    assign SDO = q.rd[7];
    assign SDO_OE_B = q.sdo_oe_b;
    assign LINK_CFG = q.link;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    logic wr_lane;
    logic wr_sub;
    logic wr_ver;
    logic wr_hd;
    assign wr_lane = wr_en && q.addr == OFF_LANE_SCR;
    assign wr_sub = wr_en && q.addr == OFF_SUB_NP;
    assign wr_ver = wr_en && q.addr == OFF_VER_SPF;
    assign wr_hd = wr_en && q.addr == OFF_HD_CF;

    a_lane_count: assert property (wr_lane |=>
        LINK_CFG.lanes_m1 == $past(wr_data[4:0]))
        else $error("lane count field not updated");
    a_scramble_flag: assert property (wr_lane |=>
        LINK_CFG.scramble_en == $past(wr_data[7]) && $stable(LINK_CFG.octets_m1))
        else $error("scramble flag not updated");
    a_octets_m1: assert property (wr_en && q.addr == OFF_OPF_M1 |=>
        LINK_CFG.octets_m1 == $past(wr_data))
        else $error("octets minus one not updated");
    a_frames_m1: assert property (wr_en && q.addr == OFF_FPM |=>
        LINK_CFG.frames_m1 == $past(wr_data[4:0]))
        else $error("frames per multiframe not updated");
    a_conv_count: assert property (wr_en && q.addr == OFF_CONV |=>
        LINK_CFG.conv_m1 == $past(wr_data))
        else $error("converter count not updated");
    a_subclass_sel: assert property (wr_sub |=>
        LINK_CFG.subclass == $past(wr_data[7:5]))
        else $error("subclass not updated");
    a_sample_width: assert property (wr_sub |=>
        LINK_CFG.sample_bits_m1 == $past(wr_data[4:0]))
        else $error("sample width not updated");
    a_samples_frame: assert property (wr_ver |=>
        LINK_CFG.samples_m1 == $past(wr_data[4:0]))
        else $error("samples per frame not updated");
    a_high_density: assert property (wr_hd |=>
        LINK_CFG.high_density == $past(wr_data[7]))
        else $error("high density flag not updated");
    a_deskew_gated: assert property (
        (LINK_CFG.deskew_mask & ~LINK_CFG.lane_enable) == 8'h00)
        else $error("deskew set on disabled lane");
    a_deskew_write: assert property (wr_en && q.addr == OFF_DESKEW |=>
        LINK_CFG.deskew_mask == ($past(wr_data) & LINK_CFG.lane_enable))
        else $error("deskew mask not updated");
    a_octets_direct: assert property (wr_en && q.addr == OFF_OPF_DIR |=>
        LINK_CFG.octets_direct == $past(wr_data))
        else $error("direct octet count not updated");
    a_lane_enable: assert property (wr_en && q.addr == OFF_LANE_EN |=>
        LINK_CFG.lane_enable == $past(wr_data))
        else $error("lane enable mask not updated");
    a_hold_idle: assert property (!wr_en |=> $stable(LINK_CFG))
        else $error("link parameters changed without a write");
    a_sdo_release: assert property (csb_s |=> SDO_OE_B)
        else $error("SDO driven while deselected");

    // Serial engine framing
    a_read_enable: assert property (sclk_rise && !csb_s && q.phase == PH_INSTR
        && q.cnt == INSTR_LAST && q.shift[RW_BIT] |=> !SDO_OE_B)
        else $error("SDO not enabled for read data");
    a_oe_read_only: assert property (!SDO_OE_B |-> q.phase == PH_DATA && q.rw)
        else $error("SDO driven outside read data");
    a_sdo_shift: assert property (sclk_fall && !csb_s && q.phase == PH_DATA && q.rw
        && q.cnt != 4'h0 |=> SDO == $past(q.rd[6]))
        else $error("read data bit not shifted");
    a_sdo_hold: assert property (!(sclk_rise || sclk_fall) |=> $stable(SDO))
        else $error("read data changed without a serial clock edge");
    a_addr_step: assert property (sclk_rise && !csb_s && q.phase == PH_DATA
        && q.cnt[2:0] == DATA_LAST |=> q.addr == $past(q.addr) + 15'h0001)
        else $error("address not stepped after a byte");

    // Engine invariants
    a_write_gate: assert property (wr_en |-> !csb_s && q.phase == PH_DATA && !q.rw)
        else $error("write outside a write data byte");
    a_write_byte: assert property (sclk_rise && !csb_s && q.phase == PH_DATA && !q.rw
        && q.cnt[2:0] == DATA_LAST |-> wr_en)
        else $error("complete write byte not stored");
    a_deselect_idle: assert property (csb_s |=> q.phase == PH_INSTR && q.cnt == 4'h0)
        else $error("deselect did not end the frame");
    a_data_count: assert property (q.phase == PH_DATA |-> q.cnt[3] == 1'b0)
        else $error("data bit count out of range");

    // Main scenarios
    c_write_any: cover property (wr_en);
    c_read_start: cover property (!q.sdo_oe_b && $past(q.sdo_oe_b));
    c_four_lanes: cover property (LINK_CFG.lanes_m1 == 5'h03 && LINK_CFG.lane_enable == 8'h0F);
    c_partial_abort: cover property (csb_s && q.phase == PH_DATA && q.cnt != 4'h0);
    c_deskew_dropped: cover property (q.regs.lane_deskew_mask != LINK_CFG.deskew_mask);

endmodule : dlpr_top

/* verif/tb_dlpr_top.sv */
// Purpose: Self-checking bench for the deframer link parameter bank
// Assumes: Serial port timing and framing as handed over with the design
// Notes:   Inputs change on the falling CLOCK edge; SCLK phases last 5 cycles

module tb_dlpr_top import dlpr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Signals, tables and model
    // ************************************************************
    localparam int LIMIT = 60000;
    localparam logic [14:0] OFFS [0:10] = '{OFF_LANE_SCR, OFF_OPF_M1, OFF_FPM, OFF_CONV,
        OFF_CS_RES, OFF_SUB_NP, OFF_VER_SPF, OFF_HD_CF, OFF_DESKEW, OFF_OPF_DIR, OFF_LANE_EN};
    // Lane setups: 0x453..0x45A, deskew, direct octets, lane enable
    localparam logic [7:0] MODES [0:4][0:10] = '{
        '{8'h83, 8'h01, 8'h1F, 8'h01, 8'h0F, 8'h2F, 8'h21, 8'h00, 8'h0F, 8'h02, 8'h0F},
        '{8'h01, 8'h01, 8'h0F, 8'h01, 8'h0F, 8'h0F, 8'h20, 8'h00, 8'h03, 8'h02, 8'h03},
        '{8'h80, 8'h03, 8'h1F, 8'h01, 8'h0F, 8'h2F, 8'h20, 8'h00, 8'h01, 8'h04, 8'h01},
        '{8'h81, 8'h00, 8'h1F, 8'h00, 8'h0F, 8'h0F, 8'h20, 8'h80, 8'h03, 8'h01, 8'h03},
        '{8'h00, 8'h01, 8'h0F, 8'h00, 8'h0F, 8'h2F, 8'h20, 8'h00, 8'h01, 8'h02, 8'h01}};
    logic CLOCK, RST_B, SCLK, CS_B, SDI, SDO, SDO_OE_B;
    dlpr_link_t LINK_CFG;
    logic [7:0] mdl [0:10];
    logic [7:0] wbuf [0:15];
    logic [7:0] rbuf [0:15];
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int m;

    dlpr_top u_dlpr_top (.CLOCK(CLOCK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B), .SDI(SDI),
        .SDO(SDO), .SDO_OE_B(SDO_OE_B), .LINK_CFG(LINK_CFG));

    // ************************************************************
    // Clock, watchdog and closing report
    // ************************************************************
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Cuts a hang short
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            $display("wrong value cycle limit expected below %0d seen %0d", LIMIT, cycles);
            stop_test();
        end
    end

    // ************************************************************
    // Compare tasks
    // ************************************************************
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %2h seen %2h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic chk_cfg(input dlpr_link_t exp);
        checked++;
        if (LINK_CFG !== exp) begin
            n_mismatch++;
            $display("wrong value link_cfg expected %h seen %h", exp, LINK_CFG);
        end
    endtask : chk_cfg

    // ************************************************************
    // Model of the bank
    // ************************************************************
    function automatic int idx_of(input logic [14:0] a);
        int k;
        idx_of = -1;
        for (k = 0; k < 11; k++) begin
            if (OFFS[k] == a) idx_of = k;
        end
    endfunction : idx_of

    // Expected decode of every field
    function automatic dlpr_link_t exp_cfg();
        dlpr_link_t c;
        c.scramble_en = mdl[0][7];
        c.lanes_m1 = mdl[0][4:0];
        c.octets_m1 = mdl[1];
        c.frames_m1 = mdl[2][4:0];
        c.conv_m1 = mdl[3];
        c.ctrl_bits = mdl[4][7:6];
        c.resolution_m1 = mdl[4][4:0];
        c.subclass = mdl[5][7:5];
        c.sample_bits_m1 = mdl[5][4:0];
        c.version = mdl[6][7:5];
        c.samples_m1 = mdl[6][4:0];
        c.high_density = mdl[7][7];
        c.ctrl_words = mdl[7][4:0];
        c.deskew_mask = mdl[8] & mdl[10];
        c.octets_direct = mdl[9];
        c.lane_enable = mdl[10];
        return c;
    endfunction : exp_cfg

    // ************************************************************
    // Serial port driver
    // ************************************************************
    task automatic half();
        repeat (5) @(negedge CLOCK);
    endtask : half

    // One SCLK pulse; SDO sampled just before the rise
    task automatic clk_bit(input logic b, output logic so, output logic oe);
        SDI = b;
        half();
        so = SDO;
        oe = SDO_OE_B;
        SCLK = 1'b1;
        half();
        SCLK = 1'b0;
    endtask : clk_bit

    // Instruction then nbits data bits, MSB first; short count aborts
    task automatic xfer(input logic rd, input logic [14:0] addr, input int nbits);
        logic so;
        logic oe;
        logic [15:0] ins;
        int i;
        ins = {rd, addr};
        CS_B = 1'b0;
        half();
        for (i = 15; i >= 0; i--) clk_bit(ins[i], so, oe);
        for (i = 0; i < nbits; i++) begin
            clk_bit(wbuf[i / 8][7 - (i % 8)], so, oe);
            rbuf[i / 8][7 - (i % 8)] = so;
            chk1("sdo_oe_b in data", ~rd, oe);
        end
        CS_B = 1'b1;
        half();
        chk1("sdo_oe_b idle", 1'b1, SDO_OE_B);
    endtask : xfer

    // Streaming write of n bytes from wbuf
    task automatic wr(input logic [14:0] addr, input int n);
        int i;
        int k;
        for (i = 0; i < n; i++) begin
            k = idx_of(addr + 15'(i));
            if (k >= 0) mdl[k] = wbuf[i];
        end
        xfer(1'b0, addr, 8 * n);
    endtask : wr

    // Streaming read of n bytes, each compared with the model
    task automatic rd(input logic [14:0] addr, input int n);
        int i;
        int k;
        xfer(1'b1, addr, 8 * n);
        for (i = 0; i < n; i++) begin
            k = idx_of(addr + 15'(i));
            chk8($sformatf("read %3h", addr + 15'(i)), (k >= 0) ? mdl[k] : UNMAPPED_RD, rbuf[i]);
        end
    endtask : rd

    task automatic rd_all();
        rd(OFF_LANE_SCR, 8);
        rd(OFF_DESKEW, 1);
        rd(OFF_OPF_DIR, 1);
        rd(OFF_LANE_EN, 1);
    endtask : rd_all

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        RST_B = 1'b0;
        SCLK = 1'b0;
        CS_B = 1'b1;
        SDI = 1'b0;
        for (m = 0; m < 16; m++) wbuf[m] = 8'h00;
        for (m = 0; m < 11; m++) mdl[m] = 8'h00;
        repeat (6) @(negedge CLOCK);
        RST_B = 1'b1;
        repeat (3) @(negedge CLOCK);
        // Values after reset
        chk_cfg(exp_cfg());
        chk1("sdo_oe_b after reset", 1'b1, SDO_OE_B);
        rd_all();
        $display("test reset values done");
        // Each documented lane setup, streamed then single writes
        for (m = 0; m < 5; m++) begin
            for (int j = 0; j < 8; j++) wbuf[j] = MODES[m][j];
            wr(OFF_LANE_SCR, 8);
            wbuf[0] = MODES[m][8];
            wr(OFF_DESKEW, 1);
            wbuf[0] = MODES[m][9];
            wr(OFF_OPF_DIR, 1);
            wbuf[0] = MODES[m][10];
            wr(OFF_LANE_EN, 1);
            chk_cfg(exp_cfg());
            rd_all();
        end
        $display("test lane setups done");
        // Deskew bits of disabled lanes dropped, register keeps them
        wbuf[0] = 8'hFF;
        wr(OFF_DESKEW, 1);
        wbuf[0] = 8'h03;
        wr(OFF_LANE_EN, 1);
        chk8("deskew_mask", 8'h03, LINK_CFG.deskew_mask);
        chk_cfg(exp_cfg());
        rd(OFF_DESKEW, 1);
        $display("test deskew gating done");
        // Unmapped places: ignored on write, zero on read
        wbuf[0] = 8'h80;
        wbuf[1] = 8'h77;
        wr(OFF_HD_CF, 2);
        wbuf[0] = 8'h5A;
        wr(15'h0460, 1);
        chk_cfg(exp_cfg());
        rd(OFF_HD_CF, 2);
        rd(15'h0460, 1);
        $display("test unmapped done");
        // Partial byte aborted by select
        wbuf[0] = 8'hAA;
        xfer(1'b0, OFF_OPF_M1, 5);
        chk_cfg(exp_cfg());
        rd(OFF_OPF_M1, 1);
        $display("test abort done");
        // Second reset in mid-run
        RST_B = 1'b0;
        repeat (6) @(negedge CLOCK);
        RST_B = 1'b1;
        repeat (3) @(negedge CLOCK);
        for (m = 0; m < 11; m++) mdl[m] = 8'h00;
        chk_cfg(exp_cfg());
        rd_all();
        $display("test second reset done");
        stop_test();
    end

endmodule : tb_dlpr_top
